// ==== bpm_pkg.sv ====
// Constants and types shared by the battery protection monitor files.
// Assumes a single 250 MHz clock and firmware-side inputs on that clock.
package bpm_pkg;

  // Clock and time base
  localparam int unsigned CLK_PERIOD_NS  = 4;
  localparam int unsigned NS_PER_SEC     = 1_000_000_000;
  localparam int unsigned SEC_CYCLES     = NS_PER_SEC / CLK_PERIOD_NS;
  localparam int unsigned SECS_PER_HOUR  = 3600;
  localparam int unsigned ISD_INTERVAL_H = 1;
  localparam int unsigned ISD_INTERVAL_S = ISD_INTERVAL_H * SECS_PER_HOUR;
  localparam int unsigned PCT_FULL       = 100;

  // Protector configuration byte layouts
  localparam int unsigned OV_SEL_LSB  = 0;
  localparam int unsigned OV_SEL_W    = 3;
  localparam int unsigned OCD_SEL_LSB = 0;
  localparam int unsigned OCD_SEL_W   = 3;
  localparam int unsigned OCC_SEL_LSB = 3;
  localparam int unsigned OCC_SEL_W   = 2;
  localparam int unsigned SCD_SEL_BIT = 5;

  // Reset values: overvoltage 111, charge OC 10, discharge OC 010, short circuit 0
  localparam logic [7:0] OV_CFG_RST = 8'h07;
  localparam logic [7:0] OC_CFG_RST = 8'h12;

  // Threshold tables
  localparam int unsigned OV_BASE_MV = 4275;
  localparam int unsigned OV_STEP_MV = 25;
  localparam logic [7:0] OCC_MV [4] = '{8'h06, 8'h0D, 8'h12, 8'h1C};
  localparam logic [7:0] OCD_MV [8] = '{8'h0E, 8'h18, 8'h22, 8'h2C,
                                        8'h35, 8'h3F, 8'h49, 8'h53};
  localparam logic [7:0] SCD_LO_MV  = 8'h49;
  localparam logic [7:0] SCD_HI_MV  = 8'h94;

  // Checksum field and command response
  localparam int unsigned SUM_W  = 7;
  localparam int unsigned RESP_W = SUM_W + 1;

  // Safety status word layout
  localparam int unsigned STATUS_W  = 16;
  localparam int unsigned ST_OTD    = 0;
  localparam int unsigned ST_ISD    = 1;
  localparam int unsigned ST_TDD    = 2;
  localparam int unsigned ST_BADSUM = 3;

  localparam int unsigned OV_MV_W = 13;

  typedef logic signed [15:0] bpm_meas_t;
  typedef logic [15:0]        bpm_uval_t;
  typedef logic [7:0]         bpm_byte_t;
  typedef logic [SUM_W-1:0]   bpm_sum_t;
  typedef logic [RESP_W-1:0]  bpm_resp_t;
  typedef logic [OV_MV_W-1:0] bpm_ov_mv_t;

  typedef enum {ISD_IDLE, ISD_ANCHORED} bpm_isd_state_t;

endpackage

// ==== bpm_prot_if.sv ====
// Signals between the monitor and its protector configuration checker.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface bpm_prot_if;
  import bpm_pkg::*;
  bpm_byte_t  ov_cfg;
  bpm_byte_t  oc_cfg;
  bpm_sum_t   stored_sum;
  logic       sum_cmd;
  logic       mismatch;
  bpm_resp_t  resp;
  logic       resp_valid;
  bpm_ov_mv_t ov_mv;
  bpm_byte_t  occ_mv;
  bpm_byte_t  ocd_mv;
  bpm_byte_t  scd_mv;

  modport owner (output ov_cfg, oc_cfg, stored_sum, sum_cmd,
                 input mismatch, resp, resp_valid, ov_mv, occ_mv, ocd_mv, scd_mv);
  modport cfg   (input ov_cfg, oc_cfg, stored_sum, sum_cmd,
                 output mismatch, resp, resp_valid, ov_mv, occ_mv, ocd_mv, scd_mv);
endinterface

// ==== bpm_prot_cfg.sv ====
// Protector checksum validation, active threshold selection and decode.
// Assumes the config bytes and stored checksum are steady firmware values.
`timescale 1ns/100ps
module bpm_prot_cfg (
  input wire logic mclk,
  input wire logic reset,
  bpm_prot_if.cfg  p
);
  import bpm_pkg::*;

  bpm_sum_t  sum_now;
  logic      bad_now;
  bpm_byte_t ov_act;
  bpm_byte_t oc_act;

  // Carry out of the sum is dropped so the top response bit stays free
  assign sum_now = SUM_W'(p.ov_cfg + p.oc_cfg);
  assign bad_now = (sum_now != p.stored_sum);

  always_ff @(posedge mclk) begin
    if (reset) begin
      p.mismatch <= 1'b0;
    end else begin
      p.mismatch <= bad_now;
    end
  end

  // Settings only move into service once the checksum agrees
  always_ff @(posedge mclk) begin
    if (reset) begin
      ov_act <= OV_CFG_RST;
      oc_act <= OC_CFG_RST;
    end else if (!bad_now) begin
      ov_act <= p.ov_cfg;
      oc_act <= p.oc_cfg;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      p.ov_mv  <= '0;
      p.occ_mv <= '0;
      p.ocd_mv <= '0;
      p.scd_mv <= '0;
    end else begin
      p.ov_mv  <= OV_MV_W'(OV_BASE_MV + OV_STEP_MV * ov_act[OV_SEL_LSB +: OV_SEL_W]);
      p.occ_mv <= OCC_MV[oc_act[OCC_SEL_LSB +: OCC_SEL_W]];
      p.ocd_mv <= OCD_MV[oc_act[OCD_SEL_LSB +: OCD_SEL_W]];
      p.scd_mv <= oc_act[SCD_SEL_BIT] ? SCD_HI_MV : SCD_LO_MV;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      p.resp       <= '0;
      p.resp_valid <= 1'b0;
    end else begin
      p.resp_valid <= p.sum_cmd;
      if (p.sum_cmd) begin
        p.resp <= {bad_now, sum_now};
      end
    end
  end

  a_sum_response: assert property (@(posedge mclk) disable iff (reset)
    p.sum_cmd |=> p.resp_valid && p.resp[RESP_W-1] == $past(bad_now))
    else $error("checksum response missing or mismatch bit wrong");

  a_cfg_held_bad: assert property (@(posedge mclk) disable iff (reset)
    bad_now |=> $stable(ov_act) && $stable(oc_act))
    else $error("protector settings changed while checksum bad");
endmodule

// ==== bpm_monitor.sv ====
// Battery protection monitor: discharge over-temperature, internal short,
// tab disconnect, body diode FET override and protector checksum checking.
// Assumes all inputs come from gauge firmware logic on mclk.
`timescale 1ns/100ps

module bpm_monitor #(
  parameter int unsigned SEC_CYCLES = bpm_pkg::SEC_CYCLES
) (
  input  wire logic                   mclk,
  input  wire logic                   reset,
  input  wire bpm_pkg::bpm_meas_t     temperature,
  input  wire bpm_pkg::bpm_meas_t     otd_limit,
  input  wire bpm_pkg::bpm_meas_t     otd_recovery,
  input  wire bpm_pkg::bpm_byte_t     otd_time_s,
  input  wire logic                   overtemp_fet_open_en,
  input  wire logic                   otd_irq_en,
  input  wire logic                   internal_short_detect_en,
  input  wire logic                   isd_irq_en,
  input  wire logic                   ocv_read,
  input  wire bpm_pkg::bpm_meas_t     passed_charge_mah,
  input  wire bpm_pkg::bpm_uval_t     design_capacity_mah,
  input  wire bpm_pkg::bpm_uval_t     isd_current_divisor,
  input  wire logic                   tab_disconnect_detect_en,
  input  wire logic                   tdd_irq_en,
  input  wire logic                   soh_update,
  input  wire bpm_pkg::bpm_byte_t     soh_pct,
  input  wire bpm_pkg::bpm_byte_t     tdd_soh_pct,
  input  wire bpm_pkg::bpm_meas_t     avg_current_ma,
  input  wire bpm_pkg::bpm_uval_t     body_diode_thresh_ma,
  input  wire logic                   ext_chg_fw_off,
  input  wire logic                   ext_dsg_fw_off,
  input  wire logic                   host_irq_en,
  input  wire logic                   trip_point_feature_en,
  input  wire logic                   safety_clear,
  input  wire bpm_pkg::bpm_byte_t     hw_overvoltage_cfg,
  input  wire bpm_pkg::bpm_byte_t     hw_overcurrent_cfg,
  input  wire bpm_pkg::bpm_sum_t      stored_protector_sum,
  input  wire logic                   compute_protector_sum_cmd,
  output logic [bpm_pkg::STATUS_W-1:0] safety_status_word,
  output logic                        dsg_overtemp_flag,
  output logic                        internal_short_flag,
  output logic                        tab_disconnect_flag,
  output logic                        bad_protector_sum_flag,
  output logic                        chg_fet_on,
  output logic                        dsg_fet_on,
  output logic                        host_irq_pin,
  output bpm_pkg::bpm_resp_t          prot_sum_resp,
  output logic                        prot_sum_resp_valid,
  output bpm_pkg::bpm_ov_mv_t         hw_ov_thresh_mv,
  output bpm_pkg::bpm_byte_t          hw_occ_thresh_mv,
  output bpm_pkg::bpm_byte_t          hw_ocd_thresh_mv,
  output bpm_pkg::bpm_byte_t          hw_scd_thresh_mv
);
  import bpm_pkg::*;

  localparam int unsigned TICK_W = 28;

  bpm_prot_if p ();

  bpm_prot_cfg u_prot_cfg (
    .mclk  (mclk),
    .reset (reset),
    .p     (p.cfg)
  );

  assign p.ov_cfg     = hw_overvoltage_cfg;
  assign p.oc_cfg     = hw_overcurrent_cfg;
  assign p.stored_sum = stored_protector_sum;
  assign p.sum_cmd    = compute_protector_sum_cmd;

  // These come straight from flops inside the checker
  assign prot_sum_resp       = p.resp;
  assign prot_sum_resp_valid = p.resp_valid;
  assign hw_ov_thresh_mv     = p.ov_mv;
  assign hw_occ_thresh_mv    = p.occ_mv;
  assign hw_ocd_thresh_mv    = p.ocd_mv;
  assign hw_scd_thresh_mv    = p.scd_mv;

  function automatic logic [15:0] sat_inc16(input logic [15:0] v);
    sat_inc16 = (v == 16'hFFFF) ? v : 16'(v + 16'h0001);
  endfunction

  function automatic logic [16:0] magnitude(input bpm_meas_t v);
    logic signed [16:0] w;
    w = 17'(v);
    magnitude = w[16] ? 17'(-w) : 17'(w);
  endfunction

  // One-second time base shared by the qualify timer and the OCV interval
  logic [TICK_W-1:0] tick_cnt;
  logic              sec_tick;

  always_ff @(posedge mclk) begin
    if (reset) begin
      tick_cnt <= '0;
      sec_tick <= 1'b0;
    end else begin
      sec_tick <= (tick_cnt == TICK_W'(SEC_CYCLES - 1));
      if (tick_cnt == TICK_W'(SEC_CYCLES - 1)) begin
        tick_cnt <= '0;
      end else begin
        tick_cnt <= TICK_W'(tick_cnt + 1'b1);
      end
    end
  end

  // Discharge over-temperature
  logic        temp_hot;
  logic        temp_cool;
  logic        otd_off;
  logic [15:0] otd_secs;
  logic        next_otd;
  logic        otd_event;

  assign temp_hot  = (temperature >= otd_limit);
  assign temp_cool = (temperature <= otd_recovery);
  assign otd_off   = (otd_time_s == 8'h00);

  always_ff @(posedge mclk) begin
    if (reset) begin
      otd_secs <= '0;
    end else if (!temp_hot || dsg_overtemp_flag || otd_off) begin
      otd_secs <= '0;
    end else if (sec_tick) begin
      otd_secs <= sat_inc16(otd_secs);
    end
  end

  // Recovery outranks the set so a misordered limit pair cannot latch the flag
  always_comb begin
    next_otd = dsg_overtemp_flag;
    if (otd_off) begin
      next_otd = 1'b0;
    end else if (temp_cool) begin
      next_otd = 1'b0;
    end else if (temp_hot && otd_secs >= 16'(otd_time_s)) begin
      next_otd = 1'b1;
    end
  end

  assign otd_event = next_otd && !dsg_overtemp_flag;

  always_ff @(posedge mclk) begin
    if (reset) begin
      dsg_overtemp_flag <= 1'b0;
    end else begin
      dsg_overtemp_flag <= next_otd;
    end
  end

  // Internal short: anchor charge at one OCV read, judge at a read an hour later
  bpm_isd_state_t     isd_state;
  bpm_meas_t          anchor_q;
  logic [15:0]        isd_elapsed;
  logic signed [16:0] dq;
  logic signed [63:0] dq_w;
  logic signed [63:0] div_w;
  logic signed [63:0] dc_w;
  logic signed [63:0] el_w;
  logic signed [63:0] hour_w;
  logic               isd_due;
  logic               isd_hit;

  assign dq      = 17'(passed_charge_mah) - 17'(anchor_q);
  assign dq_w    = 64'(dq);
  assign div_w   = 64'(isd_current_divisor);
  assign dc_w    = 64'(design_capacity_mah);
  assign el_w    = 64'(isd_elapsed);
  assign hour_w  = 64'(SECS_PER_HOUR);
  assign isd_due = (isd_state == ISD_ANCHORED) && ocv_read
                   && (isd_elapsed >= 16'(ISD_INTERVAL_S));
  // Current dq*3600/t compared against -cap/div without a divider
  assign isd_hit = isd_due && internal_short_detect_en
                   && (dq_w * hour_w * div_w <= -(dc_w * el_w));

  always_ff @(posedge mclk) begin
    if (reset) begin
      isd_state   <= ISD_IDLE;
      anchor_q    <= '0;
      isd_elapsed <= '0;
    end else if (!internal_short_detect_en) begin
      isd_state   <= ISD_IDLE;
      isd_elapsed <= '0;
    end else begin
      case (isd_state)
        ISD_IDLE: begin
          if (ocv_read) begin
            anchor_q    <= passed_charge_mah;
            isd_elapsed <= '0;
            isd_state   <= ISD_ANCHORED;
          end
        end
        ISD_ANCHORED: begin
          if (isd_due) begin
            anchor_q    <= passed_charge_mah;
            isd_elapsed <= '0;
          end else if (sec_tick) begin
            isd_elapsed <= sat_inc16(isd_elapsed);
          end
        end
        default: begin
          isd_state <= ISD_IDLE;
        end
      endcase
    end
  end

  // Hardware set wins over a software clear in the same cycle
  always_ff @(posedge mclk) begin
    if (reset) begin
      internal_short_flag <= 1'b0;
    end else if (isd_hit) begin
      internal_short_flag <= 1'b1;
    end else if (safety_clear) begin
      internal_short_flag <= 1'b0;
    end
  end

  // Tab disconnect: ratio test by cross multiplication
  bpm_byte_t   soh_prev;
  logic        have_prev;
  logic [15:0] soh_scaled;
  logic [15:0] soh_limit;
  logic        tdd_hit;

  assign soh_scaled = 16'(soh_pct) * 16'(PCT_FULL);
  assign soh_limit  = 16'(tdd_soh_pct) * 16'(soh_prev);
  assign tdd_hit    = soh_update && have_prev && tab_disconnect_detect_en
                      && (soh_scaled < soh_limit);

  always_ff @(posedge mclk) begin
    if (reset) begin
      soh_prev  <= '0;
      have_prev <= 1'b0;
    end else if (soh_update) begin
      soh_prev  <= soh_pct;
      have_prev <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      tab_disconnect_flag <= 1'b0;
    end else if (tdd_hit) begin
      tab_disconnect_flag <= 1'b1;
    end else if (safety_clear) begin
      tab_disconnect_flag <= 1'b0;
    end
  end

  // Body diode override and FET drive
  logic big_current;
  logic chg_fw_off;
  logic dsg_fw_off;
  logic chg_bd_ovr;
  logic dsg_bd_ovr;

  assign big_current = magnitude(avg_current_ma) >= 17'(body_diode_thresh_ma);
  assign chg_fw_off  = ext_chg_fw_off;
  assign dsg_fw_off  = (dsg_overtemp_flag && overtemp_fet_open_en)
                       || ext_dsg_fw_off;

  always_ff @(posedge mclk) begin
    if (reset) begin
      chg_bd_ovr <= 1'b0;
      dsg_bd_ovr <= 1'b0;
    end else begin
      chg_bd_ovr <= chg_fw_off && big_current;
      dsg_bd_ovr <= dsg_fw_off && big_current;
    end
  end

  // A bad checksum is not overridden: the protector may be misconfigured
  always_ff @(posedge mclk) begin
    if (reset) begin
      chg_fet_on <= 1'b0;
      dsg_fet_on <= 1'b0;
    end else begin
      chg_fet_on <= !p.mismatch && (!chg_fw_off || chg_bd_ovr);
      dsg_fet_on <= !p.mismatch && (!dsg_fw_off || dsg_bd_ovr);
    end
  end

  // Status word and interrupt pin
  logic irq_gate;

  assign irq_gate = host_irq_en && !trip_point_feature_en;

  always_ff @(posedge mclk) begin
    if (reset) begin
      bad_protector_sum_flag <= 1'b0;
      safety_status_word     <= '0;
    end else begin
      bad_protector_sum_flag            <= p.mismatch;
      safety_status_word                <= '0;
      safety_status_word[ST_OTD]        <= dsg_overtemp_flag;
      safety_status_word[ST_ISD]        <= internal_short_flag;
      safety_status_word[ST_TDD]        <= tab_disconnect_flag;
      safety_status_word[ST_BADSUM]     <= p.mismatch;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      host_irq_pin <= 1'b0;
    end else begin
      host_irq_pin <= irq_gate && ((otd_event && otd_irq_en)
                      || (isd_hit && isd_irq_en)
                      || (tdd_hit && tdd_irq_en));
    end
  end

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  sequence s_dsg_held;
    dsg_fw_off && big_current && !p.mismatch;
  endsequence

  sequence s_dsg_still_held;
    dsg_fw_off && !p.mismatch;
  endsequence

  a_otd_qualify: assert property (
    $rose(dsg_overtemp_flag) |-> $past(temp_hot) && !$past(otd_off)
      && $past(otd_secs) >= 16'($past(otd_time_s)))
    else $error("over-temperature flag set before qualify time");

  a_otd_fet_open: assert property (
    dsg_overtemp_flag && overtemp_fet_open_en && !big_current
      ##1 dsg_overtemp_flag && overtemp_fet_open_en |=> !dsg_fet_on)
    else $error("discharge FET not opened on over-temperature");

  a_otd_recover: assert property (
    dsg_overtemp_flag && temp_cool |=> !dsg_overtemp_flag)
    else $error("over-temperature flag did not clear on recovery");

  // Other sources share the pin, so only cycles without them are judged
  a_otd_disabled: assert property (
    otd_off && !isd_hit && !tdd_hit
      |=> !dsg_overtemp_flag && !host_irq_pin ##1 !safety_status_word[ST_OTD])
    else $error("over-temperature active with zero qualify time");

  a_isd_gated: assert property (
    $rose(internal_short_flag) |-> $past(internal_short_detect_en)
      && $past(isd_elapsed) >= 16'(ISD_INTERVAL_S))
    else $error("internal short set without enable or full interval");

  a_tdd_gated: assert property (
    $rose(tab_disconnect_flag) |-> $past(tab_disconnect_detect_en))
    else $error("tab disconnect set while detection disabled");

  a_bd_override: assert property (
    s_dsg_held ##1 s_dsg_still_held |=> dsg_fet_on)
    else $error("body diode override did not re-enable the FET");

  a_bd_release: assert property (
    dsg_bd_ovr && dsg_fw_off && !big_current ##1 dsg_fw_off
      |-> !dsg_bd_ovr ##1 !dsg_fet_on)
    else $error("body diode override did not end");

  a_bad_sum_fets: assert property (
    p.mismatch |=> !chg_fet_on && !dsg_fet_on && bad_protector_sum_flag)
    else $error("FETs closed or flag clear with bad checksum");

  a_bad_sum_word: assert property (
    p.mismatch |=> safety_status_word[ST_BADSUM])
    else $error("status word lacks bad checksum bit");

  a_irq_gate: assert property (
    host_irq_pin |-> $past(host_irq_en) && !$past(trip_point_feature_en))
    else $error("interrupt pin raised while gated off");

endmodule

// ==== bpm_host_model.sv ====
// Host side model: issues the protector checksum command and takes the reply.
// Assumes the monitor answers with a one-cycle valid pulse on mclk.
`timescale 1ns/100ps
module bpm_host_model (
  input  wire logic               mclk,
  output logic                    sum_cmd,
  input  wire bpm_pkg::bpm_resp_t resp,
  input  wire logic               resp_valid
);
  import bpm_pkg::*;
  initial sum_cmd = 1'b0;
  // One-cycle command, reply taken at the edge where valid is seen
  task automatic ask(output bpm_resp_t r, output logic got);
    got = 1'b0;
    r = '0;
    @(posedge mclk) sum_cmd <= 1'b1;
    @(posedge mclk) sum_cmd <= 1'b0;
    repeat (4) begin
      @(posedge mclk);
      if (resp_valid === 1'b1 && !got) begin
        r = resp;
        got = 1'b1;
      end
    end
  endtask
endmodule

// ==== tb_top.sv ====
// Self-checking bench for the battery protection monitor.
// Assumes a shortened second (SEC_CYCLES = 10) so the hour test stays short.
`timescale 1ns/100ps
module tb_top;
  import bpm_pkg::*;
  logic mclk = 0, reset = 1, otd_irq_en, isd_irq_en, tdd_irq_en, ocv_read, soh_update;
  logic overtemp_fet_open_en, internal_short_detect_en, tab_disconnect_detect_en;
  logic ext_chg_fw_off, ext_dsg_fw_off, host_irq_en, trip_point_feature_en, safety_clear;
  logic compute_protector_sum_cmd, dsg_overtemp_flag, internal_short_flag, got;
  logic tab_disconnect_flag, bad_protector_sum_flag, chg_fet_on, dsg_fet_on, host_irq_pin;
  logic prot_sum_resp_valid;
  logic [STATUS_W-1:0] safety_status_word;
  bpm_meas_t temperature, otd_limit, otd_recovery, passed_charge_mah, avg_current_ma;
  bpm_uval_t design_capacity_mah, isd_current_divisor, body_diode_thresh_ma;
  bpm_byte_t otd_time_s, soh_pct, tdd_soh_pct, hw_overvoltage_cfg, hw_overcurrent_cfg;
  bpm_byte_t hw_occ_thresh_mv, hw_ocd_thresh_mv, hw_scd_thresh_mv, ov, oc;
  bpm_sum_t stored_protector_sum;
  bpm_resp_t prot_sum_resp, r;
  bpm_ov_mv_t hw_ov_thresh_mv;
  int bad_count = 0, check_count = 0, cyc = 0, seed = 91679, n;
  logic [7:0] occ_t [4] = '{8'h06, 8'h0D, 8'h12, 8'h1C};
  logic [7:0] ocd_t [8] = '{8'h0E, 8'h18, 8'h22, 8'h2C, 8'h35, 8'h3F, 8'h49, 8'h53};

  always #2 mclk = ~mclk;

  bpm_monitor #(.SEC_CYCLES(10)) i_bpm_monitor (.mclk, .reset, .temperature, .otd_limit,
    .otd_recovery, .otd_time_s, .overtemp_fet_open_en, .otd_irq_en,
    .internal_short_detect_en, .isd_irq_en, .ocv_read, .passed_charge_mah,
    .design_capacity_mah, .isd_current_divisor, .tab_disconnect_detect_en, .tdd_irq_en,
    .soh_update, .soh_pct, .tdd_soh_pct, .avg_current_ma, .body_diode_thresh_ma,
    .ext_chg_fw_off, .ext_dsg_fw_off, .host_irq_en, .trip_point_feature_en, .safety_clear,
    .hw_overvoltage_cfg, .hw_overcurrent_cfg, .stored_protector_sum,
    .compute_protector_sum_cmd, .safety_status_word, .dsg_overtemp_flag,
    .internal_short_flag, .tab_disconnect_flag, .bad_protector_sum_flag, .chg_fet_on,
    .dsg_fet_on, .host_irq_pin, .prot_sum_resp, .prot_sum_resp_valid, .hw_ov_thresh_mv,
    .hw_occ_thresh_mv, .hw_ocd_thresh_mv, .hw_scd_thresh_mv);

  bpm_host_model i_bpm_host_model (.mclk, .sum_cmd(compute_protector_sum_cmd),
    .resp(prot_sum_resp), .resp_valid(prot_sum_resp_valid));

  function automatic bpm_sum_t exp_sum(bpm_byte_t a, bpm_byte_t b);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[SUM_W-1:0];
  endfunction

  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tick(int k);
    repeat (k) @(posedge mclk);
  endtask

  // Counts cycles with the interrupt pin high over a fixed span
  task automatic irq_run(int k, output int c);
    c = 0;
    repeat (k) begin
      @(posedge mclk);
      if (host_irq_pin === 1'b1) c++;
    end
  endtask

  task automatic thr_chk();
    chk("ov_mv", 16'(hw_ov_thresh_mv), 16'(OV_BASE_MV + OV_STEP_MV * ov[2:0]));
    chk("occ_mv", 16'(hw_occ_thresh_mv), 16'(occ_t[oc[4:3]]));
    chk("ocd_mv", 16'(hw_ocd_thresh_mv), 16'(ocd_t[oc[2:0]]));
    chk("scd_mv", 16'(hw_scd_thresh_mv), oc[5] ? 16'h0094 : 16'h0049);
  endtask

  task automatic close_out();
    $display("Counts: %0d checks, %0d mismatches", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 60000) begin
      bad_count++;
      close_out();
    end
  end

  initial begin
    {otd_irq_en, isd_irq_en, tdd_irq_en, ocv_read, soh_update, safety_clear} = 0;
    {overtemp_fet_open_en, internal_short_detect_en, tab_disconnect_detect_en} = 0;
    {ext_chg_fw_off, ext_dsg_fw_off, host_irq_en, trip_point_feature_en} = 0;
    {temperature, passed_charge_mah, avg_current_ma, otd_time_s, soh_pct} = 0;
    {otd_limit, otd_recovery, design_capacity_mah} = {16'd100, 16'd50, 16'd1000};
    {isd_current_divisor, body_diode_thresh_ma, tdd_soh_pct} = {16'd10, 16'd100, 8'd80};
    {ov, oc} = {OV_CFG_RST, OC_CFG_RST};
    {hw_overvoltage_cfg, hw_overcurrent_cfg, stored_protector_sum} = {ov, oc, 7'h19};
    tick(8);
    reset <= 1'b0;
    tick(4);
    thr_chk();
    // Codes 0..7 sweep every field value, then random bytes
    for (int i = 0; i < 14; i++) begin
      ov = (i < 8) ? 8'(i) : 8'($random(seed));
      oc = (i < 8) ? {2'b00, i[0], i[1:0], i[2:0]} : 8'($random(seed));
      @(posedge mclk);
      hw_overvoltage_cfg <= ov;
      hw_overcurrent_cfg <= oc;
      stored_protector_sum <= exp_sum(ov, oc);
      tick(4);
      thr_chk();
      chk("fets", {chg_fet_on, dsg_fet_on, bad_protector_sum_flag}, 3'b110);
      i_bpm_host_model.ask(r, got);
      chk("resp", {got, r}, {1'b1, 1'b0, exp_sum(ov, oc)});
    end
    // Flipping bit 6 keeps the stored sum away from any sum the low-bit edit can make
    @(posedge mclk) stored_protector_sum <= exp_sum(ov, oc) ^ 7'h40;
    @(posedge mclk) hw_overvoltage_cfg <= ov ^ 8'h07;
    tick(4);
    thr_chk();
    chk("bad", {bad_protector_sum_flag, safety_status_word[ST_BADSUM]}, 2'b11);
    chk("fets_bad", {chg_fet_on, dsg_fet_on}, 2'b00);
    i_bpm_host_model.ask(r, got);
    chk("resp_bad", {got, r}, {2'b11, exp_sum(ov ^ 8'h07, oc)});
    @(posedge mclk) hw_overvoltage_cfg <= ov;
    stored_protector_sum <= exp_sum(ov, oc);
    tick(4);
    $display("checksum test done");
    @(posedge mclk) {otd_irq_en, overtemp_fet_open_en, host_irq_en} <= 3'b111;
    {temperature, otd_time_s} <= {16'd120, 8'd1};
    irq_run(40, n);
    chk("otd_irq", 16'(n), 16'd1);
    chk("otd", {dsg_overtemp_flag, safety_status_word[ST_OTD], dsg_fet_on}, 3'b110);
    @(posedge mclk) temperature <= 16'sd50;
    tick(5);
    chk("otd_rec", {dsg_overtemp_flag, dsg_fet_on}, 2'b01);
    @(posedge mclk) {temperature, trip_point_feature_en} <= {16'd100, 1'b1};
    irq_run(40, n);
    chk("gated", {8'(n), 7'd0, dsg_overtemp_flag}, 16'h0001);
    @(posedge mclk) {temperature, trip_point_feature_en} <= {16'd40, 1'b0};
    tick(5);
    @(posedge mclk) {temperature, otd_time_s} <= {16'd120, 8'd0};
    irq_run(40, n);
    chk("otd_off", {8'(n), 6'd0, dsg_overtemp_flag, dsg_fet_on}, 16'h0001);
    $display("over-temperature test done");
    @(posedge mclk) {ext_chg_fw_off, ext_dsg_fw_off, avg_current_ma} <= {2'b11, -16'sd500};
    tick(5);
    chk("diode_on", {chg_fet_on, dsg_fet_on}, 2'b11);
    @(posedge mclk) avg_current_ma <= 16'sd99;
    tick(5);
    chk("diode_end", {chg_fet_on, dsg_fet_on}, 2'b00);
    @(posedge mclk) {ext_chg_fw_off, ext_dsg_fw_off} <= 2'b00;
    {tab_disconnect_detect_en, tdd_irq_en, soh_pct} <= {2'b11, 8'd100};
    @(posedge mclk) soh_update <= 1'b1;
    @(posedge mclk) soh_pct <= 8'd79;
    irq_run(5, n);
    chk("tdd", {8'(n), 7'd0, tab_disconnect_flag}, 16'h0101);
    @(posedge mclk) soh_update <= 1'b0;
    safety_clear <= 1'b1;
    @(posedge mclk) safety_clear <= 1'b0;
    {internal_short_detect_en, isd_irq_en, ocv_read} <= 3'b111;
    @(posedge mclk) ocv_read <= 1'b0;
    tick(36050);
    @(posedge mclk) {ocv_read, passed_charge_mah} <= {1'b1, -16'sd200};
    @(posedge mclk) ocv_read <= 1'b0;
    irq_run(5, n);
    chk("isd", {tab_disconnect_flag, internal_short_flag}, 2'b01);
    chk("isd_irq", 16'(n), 16'd1);
    // A steep health drop with detection off must leave the flag clear
    @(posedge mclk) {tab_disconnect_detect_en, soh_update, soh_pct} <= {2'b01, 8'd10};
    @(posedge mclk) soh_update <= 1'b0;
    tick(3);
    chk("tdd_off", 16'(tab_disconnect_flag), 16'd0);
    $display("detection test done");
    close_out();
  end
endmodule
